// ---- verilog/dlc_pkg.sv ----
/*
 * Shared constants and types of the local DRAM controller: host address
 * decode positions, DRAM bus widths, strobe timing counts and transfer kinds.
 * Assumes a 100 MHz core clock and 80 ns fast-page-mode DRAM parts.
 */
package dlc_pkg;

   // Core clock
   localparam int unsigned CLK_PERIOD_NS = 10;

   // Bus widths
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned MA_W          = 10;
   localparam int unsigned WORD_ADDR_W   = 18;
   localparam int unsigned HOST_ADDR_MSB = 20;
   localparam int unsigned REF_CNT_W     = 16;
   localparam int unsigned XFER_CNT_W    = 16;

   // Host address decode
   localparam int unsigned HOST_DRAM_SEL_BIT = 20;
   localparam int unsigned HOST_BANK_BIT     = 19;

   // Row/column split of an 18-bit word address
   localparam int unsigned COL_W     = 9;
   localparam int unsigned ROW_LSB   = 9;
   localparam int unsigned PAGE_SIZE = 512;

   // Burst staging buffer
   localparam int unsigned BURST_DEPTH = 8;
   localparam int unsigned BURST_AW    = 3;
   localparam int unsigned WAIT_W      = 4;

   // Strobe timing, least times rounded up to whole cycles
   localparam int unsigned T_RCD_NS = 20;
   localparam int unsigned T_CAS_NS = 20;
   localparam int unsigned T_RP_NS  = 60;
   localparam int unsigned T_RAS_NS = 80;
   localparam logic [3:0]  RCD_CYC  = 4'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  CAS_CYC  = 4'((T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  RP_CYC   = 4'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  RAS_CYC  = 4'((T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Internal transfer kinds
   typedef enum logic [1:0] {
      XFER_CFIFO_TO_DRAM,
      XFER_DRAM_TO_ENGINE,
      XFER_ENGINE_TO_DRAM,
      XFER_DRAM_TO_DISPLAY
   } dlc_xfer_e;

endpackage : dlc_pkg

// ---- verilog/dlc_mem_if.sv ----
/*
 * Carrier between the controller and its burst staging memory.
 * Assumes both ends run on the controller clock and share its enable.
 */
`timescale 1ns/1ps
interface dlc_mem_if #(
   parameter int unsigned AW = dlc_pkg::BURST_AW,
   parameter int unsigned DW = dlc_pkg::DATA_W
);
   logic          ce;
   logic          wrEn;
   logic [AW-1:0] wrAddr;
   logic [DW-1:0] wrData;
   logic [AW-1:0] rdAddr;
   logic [DW-1:0] rdData;

   modport ctrl (output ce, output wrEn, output wrAddr, output wrData, output rdAddr,
                 input rdData);
   modport mem  (input ce, input wrEn, input wrAddr, input wrData, input rdAddr,
                 output rdData);
endinterface : dlc_mem_if

// ---- verilog/dlc_burst_mem.sv ----
/*
 * Small staging memory for one page-mode write burst, read data registered.
 * Assumes the owner holds rdAddr one cycle ahead of when the data is needed.
 */
`timescale 1ns/1ps
module dlc_burst_mem #(
   parameter int unsigned DEPTH = dlc_pkg::BURST_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Port
   dlc_mem_if.mem   port
);
   logic [dlc_pkg::DATA_W-1:0] store [DEPTH];

   always_ff @(posedge ref_clk) begin
      if (port.ce && port.wrEn) begin
         store[port.wrAddr] <= port.wrData;
      end
   end

   // Reset only the read register so the data pins start defined
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         port.rdData <= '0;
      end else if (port.ce) begin
         port.rdData <= store[port.rdAddr];
      end
   end
endmodule : dlc_burst_mem

// ---- verilog/dlc_dram_ctrl.sv ----
/*
 * Local fast-page-mode DRAM controller: host access mapping, internal
 * transfers between streams and DRAM, CAS-before-RAS refresh, arbitration.
 * Assumes all inputs synchronous to ref_clk and a host that holds its request
 * until acknowledged.
 */
`timescale 1ns/1ps
module dlc_dram_ctrl #(
   parameter int unsigned BURST_DEPTH = dlc_pkg::BURST_DEPTH
) (
   // Clock, reset, enable
   input  wire logic                             ref_clk,
   input  wire logic                             rst,
   input  wire logic                             ce,
   // Refresh interval is this count plus one cycles, zero stops refresh
   input  wire logic [dlc_pkg::REF_CNT_W-1:0]    refreshCount,
   // Host access
   input  wire logic                             hostReq,
   input  wire logic [dlc_pkg::HOST_ADDR_MSB:1]  hostAddr,
   input  wire logic                             hostRnW,
   input  wire logic                             hostLds_n,
   input  wire logic                             hostUds_n,
   input  wire logic [dlc_pkg::DATA_W-1:0]       hostWdata,
   output logic                                  hostAck,
   output logic [dlc_pkg::DATA_W-1:0]            hostRdata,
   // Transfer command from the processor
   input  wire logic                             xferStart,
   input  wire dlc_pkg::dlc_xfer_e               xferKind,
   input  wire logic [dlc_pkg::WORD_ADDR_W:0]    xferAddr,
   input  wire logic [dlc_pkg::XFER_CNT_W-1:0]   xferWords,
   output logic                                  xferBusy,
   output logic                                  xferDone,
   // Stream sources
   input  wire logic [dlc_pkg::DATA_W-1:0]       cfifoData,
   input  wire logic                             cfifoValid,
   output logic                                  cfifoReady,
   input  wire logic [dlc_pkg::DATA_W-1:0]       engInData,
   input  wire logic                             engInValid,
   output logic                                  engInReady,
   // Stream sinks
   output logic [dlc_pkg::DATA_W-1:0]            readData,
   output logic                                  toEngineValid,
   output logic                                  toDisplayValid,
   // DRAM pins
   output logic [dlc_pkg::MA_W-1:0]              memAddrBus,
   output logic [dlc_pkg::DATA_W-1:0]            memDataBusOut,
   input  wire logic [dlc_pkg::DATA_W-1:0]       memDataBusIn,
   output logic                                  memDataBusOe,
   output logic                                  writeEn_n,
   output logic                                  lowerColStrobe_n,
   output logic                                  upperColStrobe_n,
   output logic [1:0]                            rowStrobe_n,
   input  wire logic                             lowerReadLatchIn,
   input  wire logic                             upperReadLatchIn
);
   localparam int unsigned AW = dlc_pkg::WORD_ADDR_W;

   typedef enum {ST_IDLE, ST_FILL, ST_SETUP, ST_RAS, ST_COLSET, ST_CASLO, ST_CASHI,
                 ST_REL, ST_REFCAS, ST_REFRAS} dlc_state_e;
   typedef enum {OWN_HOST, OWN_XFER, OWN_REF} dlc_owner_e;

   // Row phase: tenth line repeats column bit nine for 10/8 parts
   function automatic logic [dlc_pkg::MA_W-1:0] rowPhase(input logic [AW-1:0] a);
      rowPhase = {a[dlc_pkg::COL_W-1], a[AW-1:dlc_pkg::ROW_LSB]};
   endfunction : rowPhase

   function automatic logic [dlc_pkg::MA_W-1:0] colPhase(input logic [AW-1:0] a);
      colPhase = {1'b0, a[dlc_pkg::COL_W-1:0]};
   endfunction : colPhase

   dlc_state_e                   state_r, state_nxt;
   dlc_owner_e                   owner_r, owner_nxt;
   dlc_pkg::dlc_xfer_e           kind_r, kind_nxt;
   logic [3:0]                   waitCnt_r, waitCnt_nxt;
   logic [AW-1:0]                curAddr_r, curAddr_nxt;
   logic                         bank_r, bank_nxt;
   logic                         isWrite_r, isWrite_nxt;
   logic [1:0]                   lanes_r, lanes_nxt;
   logic [3:0]                   burstLen_r, burstLen_nxt;
   logic [3:0]                   wordIdx_r, wordIdx_nxt;
   logic                         xActive_r, xActive_nxt;
   logic [AW:0]                  xAddr_r, xAddr_nxt;
   logic [dlc_pkg::XFER_CNT_W-1:0] xLeft_r, xLeft_nxt;
   logic [dlc_pkg::REF_CNT_W-1:0]  refTimer_r, refTimer_nxt;
   logic                         refPend_r, refPend_nxt;
   logic                         loPrev_r, hiPrev_r, gotLo_r, gotLo_nxt, gotHi_r, gotHi_nxt;
   logic [dlc_pkg::DATA_W-1:0]   capWord_r, capWord_nxt;
   logic [dlc_pkg::MA_W-1:0]     ma_r, ma_nxt;
   logic                         oe_r, oe_nxt, we_r, we_nxt, lower_col_strobe_r, lower_col_strobe_nxt;
   logic                         upper_col_strobe_r, upper_col_strobe_nxt;
   logic [1:0]                   ras_r, ras_nxt;
   logic                         ack_r, ack_nxt, done_r, done_nxt;
   logic [dlc_pkg::DATA_W-1:0]   hRd_r, hRd_nxt, rdOut_r, rdOut_nxt;
   logic                         toEng_r, toEng_nxt, toDisp_r, toDisp_nxt;
   logic                         cfRdy_r, cfRdy_nxt, enRdy_r, enRdy_nxt;
   logic                         refStart, advance;

   dlc_mem_if #(.AW(dlc_pkg::BURST_AW), .DW(dlc_pkg::DATA_W)) memIf ();

   dlc_burst_mem #(.DEPTH(BURST_DEPTH)) u_mem (
      .ref_clk (ref_clk),
      .rst     (rst),
      .port    (memIf.mem)
   );

   // Request decode and burst sizing
   wire hostHit  = hostReq && !hostAddr[dlc_pkg::HOST_DRAM_SEL_BIT] && !ack_r;
   wire xIsWrite = (kind_r == dlc_pkg::XFER_CFIFO_TO_DRAM) ||
                   (kind_r == dlc_pkg::XFER_ENGINE_TO_DRAM);
   wire fromCfifo = (kind_r == dlc_pkg::XFER_CFIFO_TO_DRAM);
   wire [15:0] toPage = 16'(dlc_pkg::PAGE_SIZE) - {7'h00, xAddr_r[dlc_pkg::COL_W-1:0]};
   wire [15:0] pageCap = (xLeft_r < toPage) ? xLeft_r : toPage;
   // Bursts never cross a page, so one row strobe covers them
   wire [3:0]  xBurst  = (pageCap > 16'(BURST_DEPTH)) ? 4'(BURST_DEPTH) : pageCap[3:0];
   wire        srcTake = fromCfifo ? (cfifoValid && cfRdy_r) : (engInValid && enRdy_r);
   wire [3:0]  wordInc = wordIdx_r + 4'h1;
   wire        lastWord = (wordInc == burstLen_r);
   wire        loRise  = lowerReadLatchIn && !loPrev_r;
   wire        hiRise  = upperReadLatchIn && !hiPrev_r;
   wire        capDone = (gotLo_r || !lanes_r[0]) && (gotHi_r || !lanes_r[1]);
   wire        waitZero = (waitCnt_r == 4'h0);
   wire        refFire  = (refTimer_r == '0) && (refreshCount != '0);

   assign memIf.ce     = ce;
   assign memIf.rdAddr = wordIdx_nxt[dlc_pkg::BURST_AW-1:0];

   always_comb begin
      state_nxt = state_r;     owner_nxt = owner_r;     kind_nxt = kind_r;
      waitCnt_nxt = waitZero ? 4'h0 : waitCnt_r - 4'h1;
      curAddr_nxt = curAddr_r; bank_nxt = bank_r;       isWrite_nxt = isWrite_r;
      lanes_nxt = lanes_r;     burstLen_nxt = burstLen_r; wordIdx_nxt = wordIdx_r;
      xActive_nxt = xActive_r; xAddr_nxt = xAddr_r;     xLeft_nxt = xLeft_r;
      ma_nxt = ma_r;  oe_nxt = oe_r;  we_nxt = we_r;  lower_col_strobe_nxt = lower_col_strobe_r;
      upper_col_strobe_nxt = upper_col_strobe_r;  ras_nxt = ras_r;  hRd_nxt = hRd_r;  rdOut_nxt = rdOut_r;
      ack_nxt = 1'b0;  done_nxt = 1'b0;  toEng_nxt = 1'b0;  toDisp_nxt = 1'b0;
      cfRdy_nxt = cfRdy_r;  enRdy_nxt = enRdy_r;
      refStart = 1'b0;  advance = 1'b0;
      gotLo_nxt = gotLo_r;  gotHi_nxt = gotHi_r;  capWord_nxt = capWord_r;
      memIf.wrEn = 1'b0;
      memIf.wrAddr = wordIdx_r[dlc_pkg::BURST_AW-1:0];
      memIf.wrData = hostWdata;

      // Periodic refresh request; a new tick wins over the clear
      refTimer_nxt = (refTimer_r == '0) ? refreshCount : refTimer_r - 1'b1;

      // A command is taken whenever no transfer is running
      if (xferStart && !xActive_r) begin
         kind_nxt = xferKind;
         xAddr_nxt = xferAddr;
         xLeft_nxt = xferWords;
         xActive_nxt = (xferWords != '0);
         done_nxt = (xferWords == '0);
      end

      unique case (state_r)
         ST_IDLE: begin
            wordIdx_nxt = 4'h0;
            // Grants only here, between bursts, refresh first
            if (refPend_r) begin
               refStart = 1'b1;
               owner_nxt = OWN_REF;
               lower_col_strobe_nxt = 1'b0;
               upper_col_strobe_nxt = 1'b0;
               oe_nxt = 1'b0;
               waitCnt_nxt = dlc_pkg::CAS_CYC - 4'h1;
               state_nxt = ST_REFCAS;
            end else if (hostHit) begin
               owner_nxt = OWN_HOST;
               curAddr_nxt = hostAddr[AW:1];
               bank_nxt = hostAddr[dlc_pkg::HOST_BANK_BIT];
               isWrite_nxt = !hostRnW;
               lanes_nxt = {!hostUds_n, !hostLds_n};
               burstLen_nxt = 4'h1;
               memIf.wrEn = !hostRnW;
               // Single host word always sits in slot zero, whatever a burst left behind
               memIf.wrAddr = '0;
               state_nxt = ST_SETUP;
            end else if (xActive_r) begin
               owner_nxt = OWN_XFER;
               curAddr_nxt = xAddr_r[AW-1:0];
               bank_nxt = xAddr_r[AW];
               isWrite_nxt = xIsWrite;
               lanes_nxt = 2'b11;
               burstLen_nxt = xBurst;
               cfRdy_nxt = fromCfifo;
               enRdy_nxt = xIsWrite && !fromCfifo;
               state_nxt = xIsWrite ? ST_FILL : ST_SETUP;
            end
         end
         ST_FILL: begin
            // Gather the whole burst first so the page cycle never stalls
            memIf.wrData = fromCfifo ? cfifoData : engInData;
            if (srcTake) begin
               memIf.wrEn = 1'b1;
               wordIdx_nxt = lastWord ? 4'h0 : wordInc;
               if (lastWord) begin
                  cfRdy_nxt = 1'b0;
                  enRdy_nxt = 1'b0;
                  state_nxt = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            oe_nxt = isWrite_r;
            we_nxt = !isWrite_r;
            ma_nxt = rowPhase(curAddr_r);
            state_nxt = ST_RAS;
         end
         ST_RAS: begin
            ras_nxt[bank_r] = 1'b0;
            waitCnt_nxt = dlc_pkg::RCD_CYC - 4'h1;
            state_nxt = ST_COLSET;
            ma_nxt = colPhase(curAddr_r);
         end
         ST_COLSET: begin
            if (waitZero) begin
               lower_col_strobe_nxt = !lanes_r[0];
               upper_col_strobe_nxt = !lanes_r[1];
               gotLo_nxt = 1'b0;
               gotHi_nxt = 1'b0;
               waitCnt_nxt = dlc_pkg::CAS_CYC - 4'h1;
               state_nxt = ST_CASLO;
            end
         end
         ST_CASLO: begin
            if (waitZero) begin
               lower_col_strobe_nxt = 1'b1;
               upper_col_strobe_nxt = 1'b1;
               if (isWrite_r) begin
                  advance = 1'b1;
               end else begin
                  state_nxt = ST_CASHI;
               end
            end
         end
         ST_CASHI: begin
            // Wait for the returned strobes to latch the addressed lanes
            if (capDone) begin
               advance = 1'b1;
               if (owner_r == OWN_HOST) begin
                  hRd_nxt = capWord_r;
               end else begin
                  rdOut_nxt = capWord_r;
                  toEng_nxt = (kind_r == dlc_pkg::XFER_DRAM_TO_ENGINE);
                  toDisp_nxt = (kind_r == dlc_pkg::XFER_DRAM_TO_DISPLAY);
               end
            end
         end
         ST_REL: begin
            if (waitZero) begin
               state_nxt = ST_IDLE;
               ack_nxt = (owner_r == OWN_HOST);
               if (owner_r == OWN_XFER && xLeft_r == '0) begin
                  xActive_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
            end
         end
         ST_REFCAS: begin
            if (waitZero) begin
               ras_nxt = 2'b00;
               waitCnt_nxt = dlc_pkg::RAS_CYC - 4'h1;
               state_nxt = ST_REFRAS;
            end
         end
         ST_REFRAS: begin
            if (waitZero) begin
               ras_nxt = 2'b11;
               lower_col_strobe_nxt = 1'b1;
               upper_col_strobe_nxt = 1'b1;
               waitCnt_nxt = dlc_pkg::RP_CYC - 4'h1;
               state_nxt = ST_REL;
            end
         end
      endcase

      // Next column in the page, or close the burst
      if (advance) begin
         curAddr_nxt = curAddr_r + 1'b1;
         if (owner_r == OWN_XFER) begin
            xAddr_nxt = xAddr_r + 1'b1;
            xLeft_nxt = xLeft_r - 1'b1;
         end
         if (lastWord) begin
            ras_nxt = 2'b11;
            oe_nxt = 1'b0;
            waitCnt_nxt = dlc_pkg::RP_CYC - 4'h1;
            state_nxt = ST_REL;
         end else begin
            wordIdx_nxt = wordInc;
            ma_nxt = colPhase(curAddr_r + 1'b1);
            state_nxt = ST_COLSET;
         end
      end

      refPend_nxt = refFire || (refPend_r && !refStart);

      // Byte lanes latched on their own strobe's rising edge
      if (loRise) begin
         capWord_nxt[7:0] = memDataBusIn[7:0];
         gotLo_nxt = 1'b1;
      end
      if (hiRise) begin
         capWord_nxt[15:8] = memDataBusIn[15:8];
         gotHi_nxt = 1'b1;
      end
   end

   // Everything on the core clock, frozen while ce is low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;     owner_r <= OWN_REF;   kind_r <= dlc_pkg::XFER_CFIFO_TO_DRAM;
         waitCnt_r <= 4'h0;      curAddr_r <= '0;      bank_r <= 1'b0;
         isWrite_r <= 1'b0;      lanes_r <= 2'b00;     burstLen_r <= 4'h1;
         wordIdx_r <= 4'h0;      xActive_r <= 1'b0;    xAddr_r <= '0;
         xLeft_r <= '0;          refTimer_r <= '0;     refPend_r <= 1'b0;
         // Latch inputs idle high, so no false capture right after reset
         loPrev_r <= 1'b1;       hiPrev_r <= 1'b1;     gotLo_r <= 1'b0;
         gotHi_r <= 1'b0;        capWord_r <= '0;      ma_r <= '0;
         oe_r <= 1'b0;           we_r <= 1'b1;         lower_col_strobe_r <= 1'b1;
         upper_col_strobe_r <= 1'b1;         ras_r <= 2'b11;       ack_r <= 1'b0;
         done_r <= 1'b0;         hRd_r <= '0;          rdOut_r <= '0;
         toEng_r <= 1'b0;        toDisp_r <= 1'b0;     cfRdy_r <= 1'b0;
         enRdy_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;   owner_r <= owner_nxt; kind_r <= kind_nxt;
         waitCnt_r <= waitCnt_nxt; curAddr_r <= curAddr_nxt; bank_r <= bank_nxt;
         isWrite_r <= isWrite_nxt; lanes_r <= lanes_nxt; burstLen_r <= burstLen_nxt;
         wordIdx_r <= wordIdx_nxt; xActive_r <= xActive_nxt; xAddr_r <= xAddr_nxt;
         xLeft_r <= xLeft_nxt;   refTimer_r <= refTimer_nxt; refPend_r <= refPend_nxt;
         loPrev_r <= lowerReadLatchIn; hiPrev_r <= upperReadLatchIn; gotLo_r <= gotLo_nxt;
         gotHi_r <= gotHi_nxt;   capWord_r <= capWord_nxt; ma_r <= ma_nxt;
         oe_r <= oe_nxt;         we_r <= we_nxt;       lower_col_strobe_r <= lower_col_strobe_nxt;
         upper_col_strobe_r <= upper_col_strobe_nxt;     ras_r <= ras_nxt;     ack_r <= ack_nxt;
         done_r <= done_nxt;     hRd_r <= hRd_nxt;     rdOut_r <= rdOut_nxt;
         toEng_r <= toEng_nxt;   toDisp_r <= toDisp_nxt; cfRdy_r <= cfRdy_nxt;
         enRdy_r <= enRdy_nxt;
      end
   end

   // Pins straight from registers
   assign memAddrBus       = ma_r;
   assign memDataBusOut    = memIf.rdData;
   assign memDataBusOe     = oe_r;
   assign writeEn_n        = we_r;
   assign lowerColStrobe_n = lower_col_strobe_r;
   assign upperColStrobe_n = upper_col_strobe_r;
   assign rowStrobe_n      = ras_r;
   assign hostAck          = ack_r;
   assign hostRdata        = hRd_r;
   assign xferBusy         = xActive_r;
   assign xferDone         = done_r;
   assign readData         = rdOut_r;
   assign toEngineValid    = toEng_r;
   assign toDisplayValid   = toDisp_r;
   assign cfifoReady       = cfRdy_r;
   assign engInReady       = enRdy_r;
endmodule : dlc_dram_ctrl

// ---- verif/dlc_dram_ctrl_asserts.sv ----
/* Pin and handshake assertions of the local DRAM controller.
   Assumes it is bound to dlc_dram_ctrl and that the host holds its request. */
`timescale 1ns/1ps
module dlc_dram_ctrl_asserts (
   // Clock, reset, host
   input wire logic        ref_clk, rst, hostReq, hostRnW, hostLds_n, hostUds_n,
   input wire logic        hostAck, xferBusy,
   input wire logic [20:1] hostAddr,
   // DRAM pins
   input wire logic [9:0]  memAddrBus,
   input wire logic        memDataBusOe, writeEn_n, lowerColStrobe_n, upperColStrobe_n,
   input wire logic [1:0]  rowStrobe_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // One bank opened while no transfer runs can only be the host
   sequence hostRas;
      !xferBusy && $changed(rowStrobe_n) && ^rowStrobe_n;
   endsequence
   sequence casFirst;
      !lowerColStrobe_n && !upperColStrobe_n && rowStrobe_n == 2'b11;
   endsequence
   AST_ROW_ADDR: assert property (hostRas |-> $past(memAddrBus) == {hostAddr[9], hostAddr[18:10]})
      else $error("row address differs from host address");
   AST_BANK: assert property (hostRas |-> !rowStrobe_n[hostAddr[19]])
      else $error("wrong bank strobe");
   AST_WRITE_EN: assert property (hostRas |-> writeEn_n == hostRnW)
      else $error("write enable differs from host direction");
   AST_LANES: assert property (!xferBusy && ^rowStrobe_n |-> (lowerColStrobe_n || !hostLds_n) && (upperColStrobe_n || !hostUds_n))
      else $error("column strobe on a disabled lane");
   AST_CBR: assert property (rowStrobe_n == 2'b00 |-> !lowerColStrobe_n && !upperColStrobe_n)
      else $error("refresh row strobe without column strobes");
   AST_REF_RAS: assert property (casFirst ##1 rowStrobe_n == 2'b00 |-> (rowStrobe_n == 2'b00)[*8] ##1 rowStrobe_n == 2'b11)
      else $error("refresh row strobe length wrong");
   AST_DRIVE_WRITE: assert property (memDataBusOe |-> !writeEn_n)
      else $error("data bus driven outside a write");
   AST_ACK_CAUSE: assert property (hostAck |-> $past(hostReq) && !$past(hostAddr[20]))
      else $error("acknowledge without a local host request");
   AST_ACK_BOUND: assert property ($rose(hostReq) && !hostAddr[20] |-> ##[1:300] hostAck)
      else $error("host request starved");
endmodule : dlc_dram_ctrl_asserts

bind dlc_dram_ctrl dlc_dram_ctrl_asserts chk (.ref_clk, .rst, .hostReq, .hostRnW, .hostLds_n,
   .hostUds_n, .hostAck, .xferBusy, .hostAddr, .memAddrBus, .memDataBusOe, .writeEn_n,
   .lowerColStrobe_n, .upperColStrobe_n, .rowStrobe_n);

// ---- verif/dlc_dram_model.sv ----
/* Behavioural fast-page-mode DRAM array, two banks, byte lanes.
   Assumes address and data are stable a cycle before the strobes move. */
`timescale 1ns/1ps
module dlc_dram_model #(parameter int LAT = 7) (
   input wire logic [9:0]  memAddrBus,
   input wire logic [15:0] memDataBusOut,
   input wire logic        memDataBusOe, writeEn_n, lowerColStrobe_n, upperColStrobe_n,
   input wire logic [1:0]  rowStrobe_n,
   output logic [15:0]     dramQ,
   output logic            lowerReadLatchIn, upperReadLatchIn
);
   logic [15:0] mem [int];
   logic [9:0]  row, addrD;
   logic [15:0] dataD;
   logic        oeD;
   int          key;
   // Delayed copies give the strobes their hold time
   assign #1 addrD = memAddrBus;
   assign #1 dataD = memDataBusOut;
   assign #1 oeD = memDataBusOe;
   // Strobes routed back as latch enables
   assign #(LAT) lowerReadLatchIn = lowerColStrobe_n;
   assign #(LAT) upperReadLatchIn = upperColStrobe_n;
   always @(negedge rowStrobe_n[0] or negedge rowStrobe_n[1]) row = addrD;
   always @(negedge lowerColStrobe_n or negedge upperColStrobe_n) begin
      key = {!rowStrobe_n[1], row, addrD[8:0]};
      if (writeEn_n && rowStrobe_n != 2'b11) dramQ <= #(LAT) mem[key];
   end
   always @(posedge lowerColStrobe_n) if (oeD && !writeEn_n) mem[key][7:0] = dataD[7:0];
   always @(posedge upperColStrobe_n) if (oeD && !writeEn_n) mem[key][15:8] = dataD[15:8];
   // Released data goes stale instead of holding the last word
   always @(posedge (lowerReadLatchIn & upperReadLatchIn)) begin
      #15;
      if (lowerColStrobe_n && upperColStrobe_n) dramQ = ~dramQ;
   end
endmodule : dlc_dram_model

// ---- verif/test_decoder_local_dram_interface.sv ----
/* Self-checking bench of the local DRAM controller: word and byte host accesses, a foreign
   host address, the four stream transfers across page ends, refresh in the background.
   Assumes dlc_dram_model stands for the DRAM array. */
`timescale 1ns/1ps
module test_decoder_local_dram_interface;
   logic ref_clk, rst, hostReq, hostRnW, hostLds_n, hostUds_n, hostAck, xferStart, xferBusy;
   logic xferDone, cfifoValid, cfifoReady, engInReady, toEngineValid, toDisplayValid;
   logic memDataBusOe, writeEn_n, lowerColStrobe_n, upperColStrobe_n, lowerReadLatchIn;
   logic upperReadLatchIn, ce;
   logic [20:1] hostAddr, a;
   logic [18:0] xferAddr, x;
   logic [15:0] hostWdata, hostRdata, xferWords, cfifoData, readData, memDataBusOut, w, b;
   logic [15:0] memDataBusIn, dramQ, exp[$], src[$];
   logic [9:0]  memAddrBus;
   logic [1:0]  rowStrobe_n, ln;
   int          checked, mismatches;
   dlc_pkg::dlc_xfer_e xferKind;

   dlc_dram_ctrl dut (.ref_clk, .rst, .ce, .refreshCount(16'h012c), .hostReq, .hostAddr,
      .hostRnW, .hostLds_n, .hostUds_n, .hostWdata, .hostAck, .hostRdata, .xferStart, .xferKind,
      .xferAddr, .xferWords, .xferBusy, .xferDone, .cfifoData, .cfifoValid, .cfifoReady,
      .engInData(cfifoData), .engInValid(cfifoValid), .engInReady, .readData, .toEngineValid,
      .toDisplayValid, .memAddrBus, .memDataBusOut, .memDataBusIn, .memDataBusOe, .writeEn_n,
      .lowerColStrobe_n, .upperColStrobe_n, .rowStrobe_n, .lowerReadLatchIn, .upperReadLatchIn);
   dlc_dram_model mem (.memAddrBus, .memDataBusOut, .memDataBusOe, .writeEn_n, .dramQ,
      .lowerColStrobe_n, .upperColStrobe_n, .rowStrobe_n, .lowerReadLatchIn, .upperReadLatchIn);
   assign memDataBusIn = memDataBusOe ? memDataBusOut : dramQ;

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic conclude;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic hostOp(input logic [20:1] ad, input logic rnw, input logic [1:0] lanes,
                         input logic [15:0] d, input logic ack);
      int n;
      @(negedge ref_clk);
      {hostReq, hostAddr, hostRnW, hostUds_n, hostLds_n, hostWdata} = {1'b1, ad, rnw, lanes, d};
      for (n = 0; n < (ack ? 400 : 40) && hostAck !== 1'b1; n++) @(negedge ref_clk);
      hostReq = 0;
      check(16'(hostAck), 16'(ack));
      if (hostAck !== ack) conclude();
   endtask : hostOp
   task automatic xfer(input int k, input logic [18:0] ad, input int n0);
      int n;
      @(negedge ref_clk);
      {xferStart, xferAddr, xferWords} = {1'b1, ad, 16'(n0)};
      xferKind = dlc_pkg::dlc_xfer_e'(k);
      @(negedge ref_clk);
      xferStart = 0;
      for (n = 0; n < 3000 && xferDone !== 1'b1; n++) @(negedge ref_clk);
      check(16'(xferDone), 16'h1);
      if (xferDone !== 1'b1) conclude();
   endtask : xfer

   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Both stream sources share one word queue; only the selected one is ready
   always @(posedge ref_clk) if (cfifoValid && (cfifoReady || engInReady)) void'(src.pop_front());
   always @(negedge ref_clk) begin
      cfifoValid = src.size() > 0;
      cfifoData = cfifoValid ? src[0] : ~cfifoData;
   end
   always @(negedge ref_clk) if ((hostAck && hostRnW) || toEngineValid || toDisplayValid)
      check(hostAck ? hostRdata : readData, exp.size() ? exp.pop_front() : 'x);

   initial begin
      {rst, ce, hostReq, hostRnW, hostLds_n, hostUds_n, xferStart} = 7'b1101110;
      {hostAddr, hostWdata, xferAddr, xferWords, cfifoValid, cfifoData} = '0;
      xferKind = dlc_pkg::XFER_CFIFO_TO_DRAM;
      void'($urandom(20));
      repeat (3) @(negedge ref_clk);
      {rst, ce} = 2'b00;
      // Frozen: the refresh due right after reset must not have started
      repeat (6) @(negedge ref_clk);
      check({10'h0, memDataBusOe, writeEn_n, rowStrobe_n, lowerColStrobe_n, upperColStrobe_n},
            16'h001f);
      ce = 1;
      for (int i = 0; i < 6; i++) begin
         {a, w, b, ln} = {1'b0, 1'(i), 18'($urandom), 16'($urandom), 16'($urandom), 2'(i % 3)};
         hostOp(a, 0, 2'b00, w, 1);
         hostOp(a, 0, ln, b, 1);
         exp.push_back({ln[1] ? w[15:8] : b[15:8], ln[0] ? w[7:0] : b[7:0]});
         hostOp(a, 1, 2'b00, 16'h0, 1);
      end
      hostOp({1'b1, 19'($urandom)}, 1, 2'b00, 16'h0, 0);
      // Runs start near a page end; a host write competes with the filling transfer
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 10 - j; i++) src.push_back(16'($urandom));
         exp = {exp, src};
         {x, a, w} = {1'(j ^ 1), 18'h001fb + 18'(j * 1024), 20'h20000 + 20'(j), 16'($urandom)};
         fork
            xfer(2 * j, x, 10 - j);
            hostOp(a, 0, 2'b00, w, 1);
         join
         xfer(2 * j + 1, x, 10 - j);
         exp.push_back(w);
         hostOp(a, 1, 2'b00, 16'h0, 1);
      end
      @(negedge ref_clk);
      check(16'(exp.size()), 16'h0);
      conclude();
   end
endmodule : test_decoder_local_dram_interface
